// ==== src/amf_core.sv ====
// Mode port, mode registers and output word formatter of the converter
// Behaviour
// RQ1: Alternate polarity inverts every odd data bit of the output word.
// RQ2: Alternate polarity leaves even bits, overrange flag and output clock alone.
// RQ3: Receiver undoes alternate polarity by inverting odd bits again.
// RQ4: Alternate polarity and scrambler work independently, in any combination.
// RQ5: All-ones and all-zeros patterns force flag and data bits to 1 or 0.
// RQ6: Alternating pattern swaps all ones and all zeros each sample.
// RQ7: Checkerboard swaps two complementary interleaved 17-bit patterns each sample.
// RQ8: Any test pattern overrides signed coding, scrambler and alternate polarity.
// RQ9: Output disable puts data, flag and output clock in high impedance.
// RQ10: Host should nap or sleep while outputs are disabled.
// RQ11: Host waits about 2ms after sleep before trusting data.
// RQ12: Host discards 100 samples after nap, plus 50us for DC settling.
// RQ13: Power-down field: 00 normal, 10 nap, 11 sleep; register or straps.
// RQ14: Mode select high takes settings from static pin levels.
// RQ15: In strap mode chip select level turns duty stabilizer off or on.
// RQ16: In strap mode clock low gives CMOS, high gives LVDS 3.5mA, no termination.
// RQ17: Transfer spans chip select low; first 16 clock rises sample data.
// RQ18: Word is read/write bit, seven address bits, eight data bits.
// RQ19: Write stores byte; read returns register on data out, unchanged.
// RQ20: Serial data out only pulls low or releases.
// RQ21: Host issues software reset first, then programs registers.
// RQ22: Writing 1 to bit 7 of address 00h clears all mode registers.
// RQ23: Test field: 000 off, 001 zeros, 011 ones, 101 checker, 111 alternating.
// RQ24: Alternate polarity forces offset binary coding.
// RQ25: Output disable bit 0 enables outputs, 1 selects high impedance.
// RQ26: Read data shifts out MSB first during last eight clock cycles.
// RQ27: Transfer cut short before 16 bits changes no register.
`default_nettype none

module amf_core
    import amf_pkg::*;
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // Programming pins
    input  wire logic        i_prog_mode_sel,
    input  wire logic        i_cs_n,
    input  wire logic        i_sck,
    input  wire logic        i_sdi,
    input  wire logic        i_sdo,
    output logic             o_sdo,
    output logic             o_sdo_oe,
    // Sample stream from the conversion core
    input  wire logic        i_smp_valid,
    output logic             o_smp_ready,
    input  wire logic [15:0] i_smp_data,
    input  wire logic        i_smp_ovr,
    // Output drivers
    output logic      [15:0] o_dout,
    output logic             o_overrange_flag,
    output logic             o_data_output_clock,
    output logic             o_dout_oe,
    // Mode controls
    output logic      [1:0]  o_power_down_field,
    output logic             o_duty_stabilizer_enable,
    output logic      [1:0]  o_out_mode,
    output logic      [2:0]  o_lvds_current,
    output logic             o_term_on,
    output logic             o_clk_invert,
    output logic      [1:0]  o_clk_phase
);
    logic [4:0]  pins_s;
    logic        mode_s, cs_s, sck_s, sdi_s, sdo_s;
    logic        sck_d_r;
    logic        sck_rise, sck_fall;
    amf_spi_e    state_r;
    logic [4:0]  cnt_r;
    logic [14:0] shin_r;
    logic [7:0]  shout_r;
    logic        rd_act_r;
    logic [15:0] word;
    logic        word_done, wr_cmd;
    logic [7:0]  pwr_r, tim_r, om_r, fmt_r;
    logic [7:0]  fmt_eff;
    logic        hiz_eff;
    logic        fv, drain, pop;
    logic [16:0] fd;
    logic        phase_r;
    logic [16:0] raw_r;
    logic        stb_r;

    amf_sync #(.W(5)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_d       ({i_prog_mode_sel, i_cs_n, i_sck, i_sdi, i_sdo}),
        .o_q       (pins_s)
    );
    assign {mode_s, cs_s, sck_s, sdi_s, sdo_s} = pins_s;

    function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] p,
                                            input logic [7:0] t, input logic [7:0] o,
                                            input logic [7:0] f);
        unique case (a)
            ADR_PWR:     return p;
            ADR_TIMING:  return t;
            ADR_OUTMODE: return o;
            ADR_FORMAT:  return f;
            default:     return 8'h00;
        endcase
    endfunction : reg_read

    function automatic logic [16:0] fmt_word(input logic [16:0] w, input logic [7:0] f,
                                             input logic ph);
        logic [15:0] d;
        d = w[15:0];
        if (f[TC_BIT] && !f[ABP_BIT]) d[15] = ~d[15];     // RQ24
        if (f[OUTPUT_SCRAMBLE_ENABLE_BIT]) d[15:1] = d[15:1] ^ {15{d[0]}};  // RQ4
        if (f[ABP_BIT]) d = d ^ ODD_MASK;                 // RQ1 RQ2
        unique case (f[TEST_LSB+:3])                      // RQ8 RQ23
            TP_ZEROS: return 17'h00000;                   // RQ5
            TP_ONES:  return 17'h1ffff;                   // RQ5
            TP_CHECK: return ph ? CHECK_B : CHECK_A;      // RQ7
            TP_ALT:   return ph ? 17'h1ffff : 17'h00000;  // RQ6
            default:  return {w[16], d};
        endcase
    endfunction : fmt_word

    // Serial framing
    assign sck_rise  = sck_s && !sck_d_r;
    assign sck_fall  = !sck_s && sck_d_r;
    assign word      = {shin_r, sdi_s};
    assign word_done = state_r == SP_SHIFT && sck_rise && cnt_r == LAST_EDGE && !(mode_s || cs_s);
    assign wr_cmd    = word_done && !word[RW_POS];                 // RQ19 RQ27

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            sck_d_r <= 1'b0;
        end else begin
            sck_d_r <= sck_s;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state_r <= SP_IDLE;
            cnt_r   <= 5'h00;
            shin_r  <= 15'h0000;
        end else if (mode_s || cs_s) begin
            state_r <= SP_IDLE;                                    // RQ17
            cnt_r   <= 5'h00;
        end else begin
            unique case (state_r)
                SP_IDLE: begin
                    state_r <= SP_SHIFT;
                    cnt_r   <= 5'h00;
                end
                SP_SHIFT: begin
                    if (sck_rise) begin
                        shin_r <= word[14:0];                      // RQ18
                        cnt_r  <= cnt_r + 5'h01;
                        if (cnt_r == LAST_EDGE) state_r <= SP_DONE; // RQ17
                    end
                end
                SP_DONE: begin
                    state_r <= SP_DONE;
                end
            endcase
        end
    end

    // Read-back on open-drain data out
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rd_act_r <= 1'b0;
            shout_r  <= 8'h00;
            o_sdo_oe <= 1'b0;
            o_sdo    <= 1'b0;
        end else begin
            o_sdo <= 1'b0;                                         // RQ20
            if (mode_s || cs_s) begin
                rd_act_r <= 1'b0;
                o_sdo_oe <= 1'b0;
            end else if (state_r == SP_SHIFT && sck_rise && cnt_r == ADDR_DONE) begin
                rd_act_r <= shin_r[6];                             // RQ19
                shout_r  <= reg_read({shin_r[5:0], sdi_s}, pwr_r, tim_r, om_r, fmt_r);
            end else if (rd_act_r && sck_fall && state_r == SP_SHIFT
                         && cnt_r >= DATA_FIRST) begin
                o_sdo_oe <= ~shout_r[7];                           // RQ26 RQ20
                shout_r  <= {shout_r[6:0], 1'b0};
            end
        end
    end

    // Mode registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pwr_r <= REG_RST_VAL;
            tim_r <= REG_RST_VAL;
            om_r  <= REG_RST_VAL;
            fmt_r <= REG_RST_VAL;
        end else if (wr_cmd) begin
            unique case (word[14:8])
                ADR_RESET: begin
                    if (word[RST_BIT]) begin                       // RQ22
                        pwr_r <= REG_RST_VAL;
                        tim_r <= REG_RST_VAL;
                        om_r  <= REG_RST_VAL;
                        fmt_r <= REG_RST_VAL;
                    end
                end
                ADR_PWR:     pwr_r <= word[7:0];                   // RQ19
                ADR_TIMING:  tim_r <= word[7:0];
                ADR_OUTMODE: om_r  <= word[7:0];
                ADR_FORMAT:  fmt_r <= word[7:0];
                default:     pwr_r <= pwr_r;
            endcase
        end
    end

    // Mode outputs, straps or registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_power_down_field       <= PD_NORMAL;
            o_duty_stabilizer_enable <= 1'b0;
            o_out_mode               <= OMODE_CMOS;
            o_lvds_current           <= ILVDS_3P5;
            o_term_on                <= 1'b0;
            o_clk_invert             <= 1'b0;
            o_clk_phase              <= 2'b00;
        end else if (mode_s) begin                                 // RQ14
            o_power_down_field       <= {sdi_s, sdo_s};            // RQ13
            o_duty_stabilizer_enable <= cs_s;                      // RQ15
            o_out_mode               <= sck_s ? OMODE_LVDS : OMODE_CMOS; // RQ16
            o_lvds_current           <= ILVDS_3P5;                 // RQ16
            o_term_on                <= 1'b0;
            o_clk_invert             <= 1'b0;
            o_clk_phase              <= 2'b00;
        end else begin
            o_power_down_field       <= pwr_r[PD_LSB+:2];          // RQ13
            o_duty_stabilizer_enable <= tim_r[DCS_BIT];
            o_out_mode               <= om_r[OMODE_LSB+:2];
            o_lvds_current           <= om_r[ILVDS_LSB+:3];
            o_term_on                <= om_r[TERM_BIT];
            o_clk_invert             <= tim_r[CLKINV_BIT];
            o_clk_phase              <= tim_r[PHASE_LSB+:2];
        end
    end

    // Sample path
    assign fmt_eff = mode_s ? REG_RST_VAL : fmt_r;
    assign hiz_eff = !mode_s && om_r[OUTPUT_HIGH_Z_ENABLE_BIT];                  // RQ25
    assign drain   = o_power_down_field == PD_NORMAL;
    assign pop     = fv && drain;

    amf_fifo #(.WIDTH(SMP_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_valid   (i_smp_valid),
        .o_ready   (o_smp_ready),
        .i_data    ({i_smp_ovr, i_smp_data}),
        .o_valid   (fv),
        .i_ready   (drain),
        .o_data    (fd)
    );

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_dout              <= 16'h0000;
            o_overrange_flag    <= 1'b0;
            o_data_output_clock <= 1'b0;
            phase_r             <= 1'b0;
            raw_r               <= 17'h00000;
            stb_r               <= 1'b0;
        end else begin
            stb_r <= pop;
            if (pop) begin
                {o_overrange_flag, o_dout} <= fmt_word(fd, fmt_eff, phase_r);
                o_data_output_clock        <= ~o_data_output_clock; // RQ2
                phase_r                    <= ~phase_r;             // RQ6 RQ7
                raw_r                      <= fd;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_dout_oe <= 1'b0;
        end else begin
            o_dout_oe <= ~hiz_eff;                                 // RQ9 RQ25
        end
    end

    // Checks
    sequence s_word_out;
        stb_r && fmt_eff[TEST_LSB+:3] == TP_OFF;
    endsequence

    property p_odd_invert;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        s_word_out and (fmt_eff[ABP_BIT] && !fmt_eff[OUTPUT_SCRAMBLE_ENABLE_BIT] && $stable(fmt_eff))
            |-> (o_dout ^ raw_r[15:0]) == ODD_MASK;
    endproperty
    a_odd_invert: assert property (p_odd_invert) else $error("odd bits not inverted"); // RQ1

    property p_flag_keep;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        s_word_out |-> o_overrange_flag == raw_r[16];
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("overrange flag altered"); // RQ2

    property p_const_pattern;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        pop && fmt_eff[TEST_LSB+:3] == TP_ONES |=> o_overrange_flag && o_dout == 16'hffff;
    endproperty
    a_const_pattern: assert property (p_const_pattern) else $error("ones pattern wrong"); // RQ5

    property p_alt_pattern;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        stb_r && $past(fmt_eff[TEST_LSB+:3]) == TP_ALT
            |-> o_dout == {16{o_overrange_flag}} && o_overrange_flag == !phase_r;
    endproperty
    a_alt_pattern: assert property (p_alt_pattern) else $error("alternating pattern wrong"); // RQ6

    property p_check_pattern;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        stb_r && $past(fmt_eff[TEST_LSB+:3]) == TP_CHECK
            |-> {o_overrange_flag, o_dout} == (phase_r ? CHECK_A : CHECK_B);
    endproperty
    a_check_pattern: assert property (p_check_pattern) else $error("checkerboard wrong"); // RQ7

    property p_hiz;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        hiz_eff ##1 hiz_eff |-> !o_dout_oe;
    endproperty
    a_hiz: assert property (p_hiz) else $error("outputs driven while disabled"); // RQ9

    property p_strap;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        mode_s |=> o_duty_stabilizer_enable == $past(cs_s)
            && o_power_down_field == $past({sdi_s, sdo_s});
    endproperty
    a_strap: assert property (p_strap) else $error("strap levels not applied"); // RQ14

    property p_open_drain;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        1'b1 |-> !o_sdo;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data out driven high"); // RQ20

    property p_short_frame;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        state_r == SP_SHIFT && cs_s |=> $stable({pwr_r, tim_r, om_r, fmt_r});
    endproperty
    a_short_frame: assert property (p_short_frame) else $error("short frame wrote"); // RQ27

    property p_soft_reset;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        wr_cmd && word[14:8] == ADR_RESET && word[RST_BIT]
            |=> {pwr_r, tim_r, om_r, fmt_r} == 32'h00000000;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed"); // RQ22

    property p_read_keeps;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        word_done && word[RW_POS] |=> $stable({pwr_r, tim_r, om_r, fmt_r});
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read changed register"); // RQ19

    property p_edge_limit;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        state_r == SP_DONE |-> cnt_r == 5'h10;
    endproperty
    a_edge_limit: assert property (p_edge_limit) else $error("edge count past 16"); // RQ17
endmodule : amf_core

`default_nettype wire

// ==== src/amf_pkg.sv ====
// Constants and types shared by the mode port and output formatter
`default_nettype none

package amf_pkg;
    // Register addresses
    localparam logic [6:0]  ADR_RESET   = 7'h00;
    localparam logic [6:0]  ADR_PWR     = 7'h01;
    localparam logic [6:0]  ADR_TIMING  = 7'h02;
    localparam logic [6:0]  ADR_OUTMODE = 7'h03;
    localparam logic [6:0]  ADR_FORMAT  = 7'h04;
    // Field positions
    localparam int          RST_BIT     = 7;
    localparam int          PD_LSB      = 0;
    localparam int          DCS_BIT     = 0;
    localparam int          PHASE_LSB   = 1;
    localparam int          CLKINV_BIT  = 3;
    localparam int          OMODE_LSB   = 0;
    localparam int          OUTPUT_HIGH_Z_ENABLE_BIT  = 2;
    localparam int          TERM_BIT    = 3;
    localparam int          ILVDS_LSB   = 4;
    localparam int          TC_BIT      = 0;
    localparam int          OUTPUT_SCRAMBLE_ENABLE_BIT    = 1;
    localparam int          ABP_BIT     = 2;
    localparam int          TEST_LSB    = 3;
    // Serial word layout
    localparam int          WORD_BITS   = 16;
    localparam int          RW_POS      = 15;
    localparam logic [4:0]  ADDR_DONE   = 5'h07;
    localparam logic [4:0]  DATA_FIRST  = 5'h08;
    localparam logic [4:0]  LAST_EDGE   = 5'h0f;
    // Reset and coded values
    localparam logic [7:0]  REG_RST_VAL = 8'h00;
    localparam logic [1:0]  PD_NORMAL   = 2'b00;
    localparam logic [1:0]  OMODE_CMOS  = 2'b00;
    localparam logic [1:0]  OMODE_LVDS  = 2'b01;
    localparam logic [2:0]  ILVDS_3P5   = 3'b000;
    localparam logic [2:0]  TP_OFF      = 3'b000;
    localparam logic [2:0]  TP_ZEROS    = 3'b001;
    localparam logic [2:0]  TP_ONES     = 3'b011;
    localparam logic [2:0]  TP_CHECK    = 3'b101;
    localparam logic [2:0]  TP_ALT      = 3'b111;
    localparam logic [16:0] CHECK_A     = 17'h15555;
    localparam logic [16:0] CHECK_B     = 17'h0aaaa;
    localparam logic [15:0] ODD_MASK    = 16'haaaa;
    localparam int          FIFO_DEPTH  = 16;
    localparam int          SMP_WIDTH   = 17;

    typedef enum logic [1:0] {SP_IDLE, SP_SHIFT, SP_DONE} amf_spi_e;
endpackage : amf_pkg

`default_nettype wire

// ==== src/amf_sync.sv ====
// Two-flop synchroniser for a group of pin levels
`default_nettype none

module amf_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_n,
    // Levels
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            meta_r <= '0;
            o_q    <= '0;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule : amf_sync

`default_nettype wire

// ==== src/amf_fifo.sv ====
// Sample FIFO with valid/ready on both sides
`default_nettype none

module amf_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    // Fill side
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    // Drain side
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic      [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic             push;
    logic             pop;

    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_data  = mem_r[rd_r];
    assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_r[wr_r] <= i_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            wr_r    <= '0;
            rd_r    <= '0;
            cnt_r   <= '0;
            o_valid <= 1'b0;
            o_ready <= 1'b0;
        end else begin
            wr_r    <= push ? wr_r + 1'b1 : wr_r;
            rd_r    <= pop ? rd_r + 1'b1 : rd_r;
            cnt_r   <= cnt_nxt;
            o_valid <= cnt_nxt != '0;
            o_ready <= cnt_nxt != DEPTH[AW:0];
        end
    end
endmodule : amf_fifo

`default_nettype wire

// ==== testbench/amf_host.sv ====
// Host model for the serial mode port and the strap pins
`default_nettype none

module amf_host (
    // Clock
    input  wire logic i_ref_clk,
    // Port pins
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe,
    output logic      o_prog_mode_sel,
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_sdi,
    output logic      o_sdo
);
    timeunit 1ns;
    timeprecision 100ps;

    logic strap_r = 1'b0;
    logic sdo_lvl = 1'b1;

    // Pull-up on the wire; host drives it only as a strap
    assign o_sdo = i_sdo_oe ? i_sdo : (strap_r ? sdo_lvl : 1'b1);

    initial begin
        o_prog_mode_sel = 1'b0;
        o_cs_n          = 1'b1;
        o_sck           = 1'b0;
        o_sdi           = 1'b0;
    end

    // One word, cut short when n is below 16; 80 ns clock period
    task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge i_ref_clk);
        o_cs_n <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        for (int i = 15; i > 15 - n; i--) begin
            o_sck <= 1'b0;
            o_sdi <= w[i];
            repeat (3) @(posedge i_ref_clk);
            @(negedge i_ref_clk);
            rd = {rd[6:0], o_sdo};
            @(posedge i_ref_clk);
            o_sck <= 1'b1;
            repeat (4) @(posedge i_ref_clk);
        end
        o_sck <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        o_cs_n <= 1'b1;
        // Deselected line must not keep its last level
        o_sdi  <= ~o_sdi;
        repeat (6) @(posedge i_ref_clk);
    endtask : xfer

    task automatic strap(input logic [3:0] v);
        @(posedge i_ref_clk);
        strap_r         <= 1'b1;
        o_prog_mode_sel <= 1'b1;
        {o_cs_n, o_sck, o_sdi, sdo_lvl} <= v;
        repeat (6) @(posedge i_ref_clk);
    endtask : strap
endmodule : amf_host

`default_nettype wire

// ==== testbench/amf_core_tb_top.sv ====
// Self-checking bench for the mode port and output formatter
`default_nettype none

module amf_core_tb_top import amf_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        smp_valid = 1'b0;
    logic [15:0] smp_data = 16'h0000;
    logic        smp_ovr = 1'b0;
    logic        prog, cs_n, sck, sdi, sdo_w, sdo, sdo_oe, smp_ready;
    logic        ovr, dclk, dout_oe, duty_stabilizer_enable, term, clkinv;
    logic [15:0] dout;
    logic [1:0]  pd, omode, phase;
    logic [2:0]  ilvds;
    logic [7:0]  rv;
    int          errors = 0;
    int          comparisons = 0;
    int          pops = 0;
    logic [7:0]  fmts [12] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h02, 8'h06,
                               8'h0f, 8'h1f, 8'h2f, 8'h2f, 8'h3f, 8'h3f};

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    amf_host i_amf_host (.i_ref_clk(ref_clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
        .o_prog_mode_sel(prog), .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi), .o_sdo(sdo_w));

    amf_core i_amf_core (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_prog_mode_sel(prog),
        .i_cs_n(cs_n), .i_sck(sck), .i_sdi(sdi), .i_sdo(sdo_w), .o_sdo(sdo),
        .o_sdo_oe(sdo_oe), .i_smp_valid(smp_valid), .o_smp_ready(smp_ready),
        .i_smp_data(smp_data), .i_smp_ovr(smp_ovr), .o_dout(dout),
        .o_overrange_flag(ovr), .o_data_output_clock(dclk), .o_dout_oe(dout_oe),
        .o_power_down_field(pd), .o_duty_stabilizer_enable(duty_stabilizer_enable), .o_out_mode(omode),
        .o_lvds_current(ilvds), .o_term_on(term), .o_clk_invert(clkinv), .o_clk_phase(phase));

    task automatic final_report();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_out(input string nm, input logic [16:0] e, input logic [16:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_out

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        i_amf_host.xfer({1'b0, a, d}, 16, x);
    endtask : wr

    // Data bits all ones: a read that stored them would show up
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] x;
        i_amf_host.xfer({1'b1, a, 8'hff}, 16, x);
        chk_reg("readback", e, x);
    endtask : rd

    // Expected word for format byte f and pop number n since reset
    function automatic logic [16:0] fmt(input logic [7:0] f, input logic [15:0] d,
                                        input logic o, input int n);
        logic [15:0] r;
        case (f[5:3])
            3'b001: return 17'h00000;
            3'b011: return 17'h1ffff;
            3'b101: return (n % 2) ? 17'h0aaaa : 17'h15555;
            3'b111: return (n % 2) ? 17'h1ffff : 17'h00000;
            default: r = (f[0] && !f[2]) ? d ^ 16'h8000 : d;
        endcase
        if (f[1]) r = r ^ {{15{r[0]}}, 1'b0};
        if (f[2]) r = r ^ 16'haaaa;
        return {o, r};
    endfunction : fmt

    task automatic push(input logic [15:0] d, input logic o);
        logic c;
        int   k;
        c = dclk;
        k = 0;
        @(posedge ref_clk);
        smp_valid <= 1'b1;
        smp_data  <= d;
        smp_ovr   <= o;
        @(negedge ref_clk);
        chk_out("ready", 17'h00001, {16'h0000, smp_ready});
        @(posedge ref_clk);
        smp_valid <= 1'b0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (dclk === c && k < 20);
        if (k == 20) begin
            errors++;
            final_report();
        end
        pops++;
    endtask : push

    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wr(ADR_RESET, 8'h80);
        rd(ADR_PWR, 8'h00);
        rd(ADR_RESET, 8'h00);
        wr(ADR_PWR, 8'h02);
        rd(ADR_PWR, 8'h02);
        chk_out("power_down", 17'h00002, {15'h0000, pd});
        wr(ADR_PWR, 8'h00);
        repeat (100) @(posedge ref_clk);
        for (int i = 0; i < 12; i++) begin
            wr(ADR_FORMAT, fmts[i]);
            push(16'h9c35 ^ 16'(i), i[0]);
            chk_out("word", fmt(fmts[i], 16'h9c35 ^ 16'(i), i[0], pops - 1), {ovr, dout});
            if (fmts[i] == 8'h04) begin
                chk_out("decoded", {i[0], 16'h9c35 ^ 16'(i)}, {ovr, dout ^ 16'haaaa});
            end
        end
        wr(ADR_RESET, 8'h80);
        rd(ADR_FORMAT, 8'h00);
        i_amf_host.xfer({1'b0, ADR_FORMAT, 8'h3f}, 10, rv);
        rd(ADR_FORMAT, 8'h00);
        wr(ADR_TIMING, 8'h5a);
        repeat (2) rd(ADR_TIMING, 8'h5a);
        chk_reg("timing_outs", 8'h0a, {4'h0, clkinv, phase, duty_stabilizer_enable});
        wr(ADR_PWR, 8'h03);
        chk_out("power_down", 17'h00003, {15'h0000, pd});
        wr(ADR_PWR, 8'h00);
        repeat (200) @(posedge ref_clk);
        wr(ADR_PWR, 8'h02);
        wr(ADR_OUTMODE, 8'h04);
        chk_out("outputs_on", 17'h00000, {16'h0000, dout_oe});
        wr(ADR_OUTMODE, 8'h00);
        chk_out("outputs_on", 17'h00001, {16'h0000, dout_oe});
        i_amf_host.strap(4'b1111);
        chk_out("strap_modes", 17'h00017, {8'h00, ilvds, term, duty_stabilizer_enable, omode, pd});
        i_amf_host.strap(4'b0010);
        chk_out("strap_modes", 17'h00002, {8'h00, ilvds, term, duty_stabilizer_enable, omode, pd});
        final_report();
    end
endmodule : amf_core_tb_top

`default_nettype wire
